// ---- hdl/pcp_map.svh ----
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH
// register indices on the management frame
`define PCP_REG_CTRL       5'h00
`define PCP_REG_PWR        5'h10
// basic control field positions and reset image
`define PCP_CTRL_RST_BIT   15
`define PCP_CTRL_AN_RSTRT  9
`define PCP_CTRL_PD_BIT    11
`define PCP_CTRL_DEFAULT   16'h3080
// power status and control fields
`define PCP_PWR_DYN_BIT    13
`define PCP_PWR_ST_HI      10
`define PCP_PWR_ST_LO      9
// management frame opcodes and field sizes
`define PCP_OP_READ        2'h2
`define PCP_OP_WRITE       2'h1
`define PCP_HDR_LAST       5'h0B
`define PCP_DATA_LAST      5'h0F
`define PCP_TA_LAST        5'h01
// timing: quiet threshold in ms, core clock in kHz
`define PCP_QUIET_MS       6600
`define PCP_CLK_KHZ        40000
`define PCP_SOFT_RST_CYC   4
`endif

// ---- hdl/pcp_pkg.sv ----
package pcp_pkg;
  // management frame receiver states
  typedef enum logic [1:0] {
    MF_IDLE,
    MF_HDR,
    MF_TA,
    MF_DATA
  } pcp_mf_state_type;
endpackage

// ---- hdl/pcp_power_manager.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"

// Summary of operation
// - dynamic mode enters reduced power when unplugged
// - reduced power shuts link circuits, energy sensing stays
// - management access fully works in reduced power
// - reduced power switches host link to 10 Mbps
// - over 6.6 s quiet clears cable present
// - energy in reduced power sets flag quickly
// - activity judged from line energy only
// - dynamic exit needs request cleared and plugged
// - non-dynamic: reduced power follows host request OR control bit 11 only
// - dynamic enable bit 13, reset disabled
// - status bits 10:9 read one in reduced power
// - control bit 11 ORed with host request
// - registers reached by management frames
// - control bit 15 soft reset, self clearing
module pcp_power_manager
  import pcp_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR     = 5'h01,
  parameter int unsigned QUIET_CYCLES = `PCP_QUIET_MS * `PCP_CLK_KHZ
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_line_energy,
  input  wire logic i_host_pd_req,
  input  wire logic i_mgmt_clk,
  input  wire logic i_mgmt_data,
  output var  logic o_mgmt_data,
  output var  logic o_mgmt_data_oe,
  output var  logic o_cable_present_flag,
  output var  logic o_reduced_power,
  output var  logic o_link_power_down,
  output var  logic o_host_speed_10
);

  // synchroniser stages for pin inputs
  logic [1:0]  energy_sync_q;   // line energy detector
  logic [1:0]  hreq_sync_q;     // host power-down request
  logic [1:0]  mclk_sync_q;     // management clock
  logic [1:0]  mdat_sync_q;     // management data
  logic        mclk_prev_q;     // edge finder on synced clock
  logic        mclk_rise;       // one-cycle rising edge

  // power state
  logic        present_q;       // cable present flag
  logic [31:0] quiet_cnt_q;     // cycles without line energy
  logic        red_q;           // the single reduced power flop
  logic        pd_cmd;          // effective power-down command

  // registers
  logic [15:0] ctrl_q;          // basic control, bit 15 kept zero
  logic        dyn_en_q;        // dynamic reduced power enable
  logic [2:0]  soft_cnt_q;      // soft reset in progress
  logic        soft_busy;

  // management frame engine
  pcp_mf_state_type mf_state_q;
  logic [4:0]  bit_cnt_q;       // bit position within a field
  logic [10:0] hdr_sh_q;        // header shifter
  logic [11:0] hdr_full;        // header incl. current bit
  logic        is_rd_q;         // read frame for this device
  logic        is_wr_q;         // write frame for this device
  logic [4:0]  reg_idx_q;       // addressed register
  logic [15:0] dsh_q;           // data shifter both ways
  logic        wr_pulse_q;      // commit of a write frame
  logic [4:0]  wr_idx_q;
  logic [15:0] wr_data_q;
  logic        mdo_q;
  logic        mdo_oe_q;
  logic [15:0] rdata;           // read mux

  // two flops on every pin before any logic looks at it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      energy_sync_q <= 2'h0;
      hreq_sync_q   <= 2'h0;
      mclk_sync_q   <= 2'h0;
      mdat_sync_q   <= 2'h3;
      mclk_prev_q   <= 1'h0;
    end else begin
      energy_sync_q <= {energy_sync_q[0], i_line_energy};
      hreq_sync_q   <= {hreq_sync_q[0], i_host_pd_req};
      mclk_sync_q   <= {mclk_sync_q[0], i_mgmt_clk};
      mdat_sync_q   <= {mdat_sync_q[0], i_mgmt_data};
      mclk_prev_q   <= mclk_sync_q[1];
    end
  end

  // edge of the link clock, from the second stage only
  assign mclk_rise = mclk_sync_q[1] & ~mclk_prev_q;

  // quiet timer and cable flag
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      present_q   <= 1'h1;
      quiet_cnt_q <= 32'h0;
    end else if (energy_sync_q[1]) begin
      quiet_cnt_q <= 32'h0;
      present_q   <= 1'h1;
    end else if (quiet_cnt_q >= QUIET_CYCLES) begin
      present_q   <= 1'h0;
    end else begin
      quiet_cnt_q <= quiet_cnt_q + 32'h1;
    end
  end

  assign pd_cmd = hreq_sync_q[1] | ctrl_q[`PCP_CTRL_PD_BIT];

  // power state decision
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      red_q <= 1'h0;
    end else if (dyn_en_q) begin
      if (!red_q) begin
        red_q <= ~present_q | pd_cmd;
      end else begin
        red_q <= ~(present_q & ~pd_cmd);
      end
    end else begin
      red_q <= pd_cmd;
    end
  end

  assign o_reduced_power      = red_q;
  assign o_link_power_down    = red_q;
  assign o_host_speed_10      = red_q;
  assign o_cable_present_flag = present_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      soft_cnt_q <= 3'h0;
    end else if (soft_cnt_q != 3'h0) begin
      soft_cnt_q <= soft_cnt_q - 3'h1;
    end else if (wr_pulse_q && wr_idx_q == `PCP_REG_CTRL
                 && wr_data_q[`PCP_CTRL_RST_BIT]) begin
      soft_cnt_q <= 3'(`PCP_SOFT_RST_CYC);
    end
  end

  assign soft_busy = (soft_cnt_q != 3'h0);

  // basic control register; writes during soft reset are lost
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || soft_busy) begin
      ctrl_q <= `PCP_CTRL_DEFAULT;
    end else if (wr_pulse_q && wr_idx_q == `PCP_REG_CTRL) begin
      // reset bit loads defaults at once
      if (wr_data_q[`PCP_CTRL_RST_BIT]) begin
        ctrl_q <= `PCP_CTRL_DEFAULT;
      end else begin
        ctrl_q <= wr_data_q;
      end
    end else begin
      // restart bit is self clearing; nothing to restart here
      ctrl_q[`PCP_CTRL_AN_RSTRT] <= 1'h0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || soft_busy) begin
      dyn_en_q <= 1'h0;
    end else if (wr_pulse_q && wr_idx_q == `PCP_REG_PWR) begin
      dyn_en_q <= wr_data_q[`PCP_PWR_DYN_BIT];
    end
  end

  // read mux; unmapped registers read zero
  always_comb begin
    rdata = 16'h0;
    if (reg_idx_q == `PCP_REG_CTRL) begin
      rdata = ctrl_q;
      rdata[`PCP_CTRL_RST_BIT] = soft_busy;
    end else if (reg_idx_q == `PCP_REG_PWR) begin
      rdata[`PCP_PWR_DYN_BIT] = dyn_en_q;
      rdata[`PCP_PWR_ST_HI] = red_q;
      rdata[`PCP_PWR_ST_LO] = red_q;
    end
  end

  assign hdr_full = {hdr_sh_q, mdat_sync_q[1]};

  // frame engine, never gated by power
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mf_state_q <= MF_IDLE;
      bit_cnt_q  <= 5'h0;
      // last seen bit starts as idle one, so preamble is no false start
      hdr_sh_q   <= 11'h001;
      is_rd_q    <= 1'h0;
      is_wr_q    <= 1'h0;
      reg_idx_q  <= 5'h0;
      dsh_q      <= 16'h0;
      wr_pulse_q <= 1'h0;
      wr_idx_q   <= 5'h0;
      wr_data_q  <= 16'h0;
      mdo_q      <= 1'h1;
      mdo_oe_q   <= 1'h0;
    end else begin
      wr_pulse_q <= 1'h0;
      if (mclk_rise) begin
        unique case (mf_state_q)
          // preamble ones then start pair; last bit kept in hdr_sh_q[0]
          MF_IDLE: begin
            hdr_sh_q[0] <= mdat_sync_q[1];
            bit_cnt_q   <= 5'h0;
            if (!hdr_sh_q[0] && mdat_sync_q[1]) begin
              mf_state_q <= MF_HDR;
            end
          end
          // opcode, device address, register index
          MF_HDR: begin
            hdr_sh_q  <= hdr_full[10:0];
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == `PCP_HDR_LAST) begin
              mf_state_q <= MF_TA;
              bit_cnt_q  <= 5'h0;
              reg_idx_q  <= hdr_full[4:0];
              is_rd_q <= (hdr_full[11:10] == `PCP_OP_READ) && (hdr_full[9:5] == PHY_ADDR);
              is_wr_q <= (hdr_full[11:10] == `PCP_OP_WRITE) && (hdr_full[9:5] == PHY_ADDR);
            end
          end
          // turnaround: take the line for a read
          MF_TA: begin
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == 5'h0 && is_rd_q) begin
              mdo_oe_q <= 1'h1;
              mdo_q    <= 1'h0;
            end
            if (bit_cnt_q == `PCP_TA_LAST) begin
              mf_state_q <= MF_DATA;
              bit_cnt_q  <= 5'h0;
              if (is_rd_q) begin
                mdo_q <= rdata[15];
                dsh_q <= {rdata[14:0], 1'h0};
              end
            end
          end
          // sixteen data bits, msb first
          MF_DATA: begin
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (is_rd_q) begin
              mdo_q <= dsh_q[15];
              dsh_q <= {dsh_q[14:0], 1'h0};
            end else begin
              dsh_q <= {dsh_q[14:0], mdat_sync_q[1]};
            end
            if (bit_cnt_q == `PCP_DATA_LAST) begin
              mf_state_q  <= MF_IDLE;
              hdr_sh_q[0] <= 1'h1;
              mdo_oe_q    <= 1'h0;
              mdo_q       <= 1'h1;
              wr_pulse_q  <= is_wr_q;
              wr_idx_q    <= reg_idx_q;
              wr_data_q   <= {dsh_q[14:0], mdat_sync_q[1]};
            end
          end
        endcase
      end
    end
  end

  assign o_mgmt_data    = mdo_q;
  assign o_mgmt_data_oe = mdo_oe_q;

  // ---- assertions ----
  a_quiet_unplug:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (quiet_cnt_q >= QUIET_CYCLES && !energy_sync_q[1]) |=> !present_q)
    else $error("cable flag not cleared after quiet interval");

  a_energy_plug:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      energy_sync_q[1] |=> (present_q && quiet_cnt_q == 32'h0))
    else $error("energy did not set cable flag");

  a_dyn_enter:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (dyn_en_q && !present_q) |=> red_q)
    else $error("dynamic mode missed reduced power entry");

  a_dyn_hold:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (dyn_en_q && red_q && (pd_cmd || !present_q)) |=> red_q)
    else $error("left reduced power without both conditions");

  a_static_follow:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !dyn_en_q |=> (red_q == $past(pd_cmd)))
    else $error("static mode does not follow request");

  a_status_bits:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (reg_idx_q == `PCP_REG_PWR) |->
        (rdata[`PCP_PWR_ST_HI:`PCP_PWR_ST_LO] == {2{red_q}}))
    else $error("status bits disagree with power state");

  a_soft_reset:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(soft_busy) |-> (ctrl_q == `PCP_CTRL_DEFAULT) [*4] ##1 !soft_busy)
    else $error("soft reset length or defaults wrong");

  a_line_release:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (mf_state_q == MF_IDLE || mf_state_q == MF_HDR) |-> !mdo_oe_q)
    else $error("data line driven outside read phase");

  a_dyn_default:
    assert property (@(posedge i_clk_sys)
      $fell(i_rst) |-> !dyn_en_q)
    else $error("dynamic mode enabled after reset");

endmodule

`default_nettype wire

// ---- bench/pcp_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host-side controller: issues management frames, clock parked low between frames
module pcp_mac_model (
  input  wire logic i_clk_sys,
  input  wire logic i_wire,
  output var  logic o_mgmt_clk,
  output var  logic o_drv_data,
  output var  logic o_drv_oe
);
  // idle: clock still, pin released so the pull-up shows
  initial begin
    o_mgmt_clk = 1'b0;
    o_drv_data = 1'b1;
    o_drv_oe   = 1'b0;
  end

  // one bit: change while low, sample late in the low half, then rise
  task automatic send_bit(input logic d, input logic drv, output logic s);
    @(posedge i_clk_sys);
    o_mgmt_clk <= 1'b0;
    o_drv_data <= d;
    o_drv_oe   <= drv;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    s = i_wire;
    @(posedge i_clk_sys);
    o_mgmt_clk <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
  endtask

  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] idx,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [47:0] hdr;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, idx, 2'b10};
    // turnaround released on reads so the device can take the pin
    for (int i = 47; i >= 0; i--) send_bit(hdr[i], !(rd && i < 2), s);
    for (int i = 15; i >= 0; i--) begin
      send_bit(wd[i], !rd, s);
      rdat[i] = s;
    end
    @(posedge i_clk_sys);
    o_mgmt_clk <= 1'b0;
    o_drv_oe   <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcp_map.svh"
module tb_top;
  localparam int unsigned QUIET = 200; // shortened quiet span
  logic        clk_sys, rst, line_energy, host_pd_req, oe_seen;
  logic        mgmt_clk, mac_data, mac_oe, dev_data, dev_oe, mgmt_wire;
  logic        cable_flag, reduced, link_pd, speed_10;
  logic [15:0] rd;
  logic [4:0]  idx;
  int          n_fail, check_count, gap;
  // pull-up wins when nobody drives
  assign mgmt_wire = dev_oe ? dev_data : (mac_oe ? mac_data : 1'b1);
  always #12.5 clk_sys = ~clk_sys;
  // any device drive during refused frames
  always @(posedge clk_sys) if (dev_oe === 1'b1) oe_seen <= 1'b1;

  pcp_power_manager #(.PHY_ADDR(5'h01), .QUIET_CYCLES(QUIET)) i_pcp_power_manager (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_line_energy(line_energy),
    .i_host_pd_req(host_pd_req), .i_mgmt_clk(mgmt_clk), .i_mgmt_data(mgmt_wire),
    .o_mgmt_data(dev_data), .o_mgmt_data_oe(dev_oe), .o_cable_present_flag(cable_flag),
    .o_reduced_power(reduced), .o_link_power_down(link_pd), .o_host_speed_10(speed_10));
  pcp_mac_model i_pcp_mac_model (
    .i_clk_sys(clk_sys), .i_wire(mgmt_wire), .o_mgmt_clk(mgmt_clk),
    .o_drv_data(mac_data), .o_drv_oe(mac_oe));

  // expected register images
  function automatic logic [15:0] pwr_word(input logic dyn, input logic red);
    return {2'b00, dyn, 2'b00, red, red, 9'h000};
  endfunction
  function automatic logic [15:0] ctrl_word(input logic pd);
    return `PCP_CTRL_DEFAULT | {4'h0, pd, 11'h000};
  endfunction

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // all three power outputs move together
  task automatic chk_pwr(input logic exp);
    chk_bit(reduced, exp);
    chk_bit(link_pd, exp);
    chk_bit(speed_10, exp);
  endtask
  // settle past the edge before looking
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    i_pcp_mac_model.frame(1'b0, 5'h01, a, d, dummy);
    cyc(6);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] got;
    i_pcp_mac_model.frame(1'b1, 5'h01, a, 16'h0000, got);
    chk_word(got, exp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    line_energy = 1'b1;
    host_pd_req = 1'b0;
    oe_seen = 1'b0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(32'h5db8fe02));
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    // defaults after reset
    chk_bit(cable_flag, 1'b1);
    chk_pwr(1'b0);
    rdchk(`PCP_REG_CTRL, ctrl_word(1'b0));
    rdchk(`PCP_REG_PWR, pwr_word(1'b0, 1'b0));
    // unmapped index: write lost, reads zero
    idx = 5'h11 + 5'($urandom_range(14));
    wr(idx, 16'hFFFF);
    rdchk(idx, 16'h0000);
    // foreign phy address: no write, no drive; earlier reads drove the pin
    oe_seen = 1'b0;
    i_pcp_mac_model.frame(1'b0, 5'h02 + 5'($urandom_range(29)), `PCP_REG_CTRL, 16'h0800, rd);
    i_pcp_mac_model.frame(1'b1, 5'h1F, `PCP_REG_CTRL, 16'h0000, rd);
    chk_bit(oe_seen, 1'b0);
    rdchk(`PCP_REG_CTRL, ctrl_word(1'b0));
    // host request alone, dynamic mode off
    host_pd_req <= 1'b1;
    cyc(6);
    chk_pwr(1'b1);
    rdchk(`PCP_REG_PWR, pwr_word(1'b0, 1'b1));
    host_pd_req <= 1'b0;
    cyc(6);
    chk_pwr(1'b0);
    // manual power-down bit
    wr(`PCP_REG_CTRL, ctrl_word(1'b1));
    chk_pwr(1'b1);
    rdchk(`PCP_REG_CTRL, ctrl_word(1'b1));
    wr(`PCP_REG_CTRL, ctrl_word(1'b0));
    chk_pwr(1'b0);
    // quiet span broken by a one-cycle energy blip restarts the count
    line_energy <= 1'b0;
    gap = QUIET / 2 + $urandom_range(QUIET / 4);
    cyc(gap);
    line_energy <= 1'b1;
    cyc(1);
    line_energy <= 1'b0;
    cyc(QUIET - 10);
    chk_bit(cable_flag, 1'b1);
    cyc(30);
    chk_bit(cable_flag, 1'b0);
    chk_pwr(1'b0);
    // dynamic mode while unplugged
    wr(`PCP_REG_PWR, pwr_word(1'b1, 1'b0));
    chk_pwr(1'b1);
    rdchk(`PCP_REG_PWR, pwr_word(1'b1, 1'b1));
    // energy returns with request still set: plugged but stays down
    host_pd_req <= 1'b1;
    line_energy <= 1'b1;
    cyc(8);
    chk_bit(cable_flag, 1'b1);
    chk_pwr(1'b1);
    host_pd_req <= 1'b0;
    cyc(6);
    chk_pwr(1'b0);
    // soft reset returns both registers to defaults
    wr(`PCP_REG_CTRL, 16'h8000);
    cyc(8);
    rdchk(`PCP_REG_CTRL, ctrl_word(1'b0));
    rdchk(`PCP_REG_PWR, pwr_word(1'b0, 1'b0));
    close_out();
  end
endmodule
`default_nettype wire
